// [hw/silence_map.svh]
/*
  register offsets, field positions, reset values and timing counts for the
  communication-silence supervisor. assumes inclusion by bare name.
*/
`ifndef SILENCE_MAP_SVH
`define SILENCE_MAP_SVH
// apb byte addresses
`define ADDR_LINK_SILENCE_FAULT_CONFIG 12'h028
`define ADDR_SILENCE_COUNTER 12'h02C
`define ADDR_SILENCE_CONTROL 12'h030
`define ADDR_SYSTEM_FAULT_REG 12'h034
// field positions
`define CFG_PD_MSB 7
`define CFG_PD_LSB 4
`define CFG_FAULT_MSB 3
`define CFG_FAULT_LSB 0
`define CTL_CLEAR_INHIBIT_BIT 0
`define FAULT_LINK_SILENCE_BIT 0
// reset values
`define CFG_RESET 8'h00
`define CTL_RESET 1'b0
// timing: system clock 250 MHz, tick source 4 kHz
`define SYS_CLK_HZ 250000000
`define TICK_HZ 4000
`define TICK_DIV (`SYS_CLK_HZ / `TICK_HZ)
`define CNT_WIDTH 24
// period ladder in 4 kHz ticks: 0.1 s .. 1 h
`define TICKS_CODE1 24'd400
`define TICKS_CODE2 24'd2000
`define TICKS_CODE3 24'd4000
`define TICKS_CODE4 24'd8000
`define TICKS_CODE5 24'd20000
`define TICKS_CODE6 24'd40000
`define TICKS_CODE7 24'd120000
`define TICKS_CODE8 24'd240000
`define TICKS_CODE9 24'd480000
`define TICKS_CODE10 24'd1200000
`define TICKS_CODE11 24'd2400000
`define TICKS_CODE12 24'd7200000
`define TICKS_CODE13 24'd14400000
`endif

// [hw/silence_pkg.sv]
/*
  types for the communication-silence supervisor.
  assumes silence_map.svh is available on the include path.
*/
package silence_pkg;
  typedef logic [3:0] period_code_t;
  typedef logic [23:0] tick_count_t;
endpackage

// [hw/comm_silence_timeout.sv]
/*
  communication-silence supervisor: apb registers, 4 kHz tick prescaler,
  shared 24-bit silence counter, timeout fault and power-down request.
  assumes i_frame_valid pulses one cycle per valid received frame, synchronous
  to I_REF_CLK, and that the apb master follows the usual two-phase protocol.
*/
`timescale 1ns/10ps
`include "silence_map.svh"

// Behaviour
// - power-down period code sits in config bits 7:4; zero disables power-down
// - power-down codes 1..13 map to 0.1 s up to 1 h
// - power down after a full selected period without a valid frame
// - timeout-fault period code sits in config bits 3:0; zero disables fault
// - fault codes 1..13 use the same 0.1 s to 1 h ladder
// - set link silence fault flag after selected fault period without frames
// - one shared 24-bit up-counter at 4 kHz times both periods
// - software write loads counter; reads meaningful only with clearing inhibited
module comm_silence_timeout
  import silence_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // link side
  input wire logic I_FRAME_VALID,
  // status outputs
  output logic O_LINK_SILENCE_FAULT,
  output logic O_POWERDOWN
);

  // reference clocks per 4 kHz tick; a 16-bit prescaler is just wide enough
  localparam int TICK_DIV = `TICK_DIV;
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

  logic [7:0] link_silence_fault_config;
  logic counter_clear_inhibit;
  tick_count_t silence_counter;
  logic [15:0] prescale;
  logic link_silence_fault;
  logic powerdown;
  logic [31:0] prdata;
  logic pslverr;

  logic [7:0] next_config;
  logic next_inhibit;
  tick_count_t next_counter;
  logic [15:0] next_prescale;
  logic next_fault;
  logic next_powerdown;
  logic [31:0] next_prdata;
  logic next_pslverr;

  logic wr_en;
  logic rd_en;
  logic tick;
  logic addr_hit;
  period_code_t pd_code;
  period_code_t fault_code;
  tick_count_t pd_limit;
  tick_count_t fault_limit;

  // ladder decode; reserved codes decode as disabled so they never fire
  function automatic tick_count_t period_ticks(input period_code_t code);
    tick_count_t t;
    t = 24'h000000;
    unique case (code)
      4'h1: t = `TICKS_CODE1;
      4'h2: t = `TICKS_CODE2;
      4'h3: t = `TICKS_CODE3;
      4'h4: t = `TICKS_CODE4;
      4'h5: t = `TICKS_CODE5;
      4'h6: t = `TICKS_CODE6;
      4'h7: t = `TICKS_CODE7;
      4'h8: t = `TICKS_CODE8;
      4'h9: t = `TICKS_CODE9;
      4'hA: t = `TICKS_CODE10;
      4'hB: t = `TICKS_CODE11;
      4'hC: t = `TICKS_CODE12;
      4'hD: t = `TICKS_CODE13;
      default: t = 24'h000000; // zero, 14 and 15: no timeout
    endcase
    return t;
  endfunction

  // apb decode; zero-wait slave, answer in the access cycle
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_en = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign addr_hit = (I_PADDR == `ADDR_LINK_SILENCE_FAULT_CONFIG) || (I_PADDR == `ADDR_SILENCE_COUNTER) ||
                    (I_PADDR == `ADDR_SILENCE_CONTROL) || (I_PADDR == `ADDR_SYSTEM_FAULT_REG);
  assign pd_code = link_silence_fault_config[`CFG_PD_MSB:`CFG_PD_LSB];
  assign fault_code = link_silence_fault_config[`CFG_FAULT_MSB:`CFG_FAULT_LSB];
  assign pd_limit = period_ticks(pd_code);
  assign fault_limit = period_ticks(fault_code);
  assign tick = (prescale == TICK_LAST);

  // configuration and control: only a completed access phase writes them
  always_comb begin
    next_config = link_silence_fault_config;
    next_inhibit = counter_clear_inhibit;
    if (wr_en && I_PADDR == `ADDR_LINK_SILENCE_FAULT_CONFIG) begin
      next_config = I_PWDATA[7:0];
    end
    if (wr_en && I_PADDR == `ADDR_SILENCE_CONTROL) begin
      next_inhibit = I_PWDATA[`CTL_CLEAR_INHIBIT_BIT];
    end
  end

  // configuration registers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      link_silence_fault_config <= `CFG_RESET;
      counter_clear_inhibit <= `CTL_RESET;
    end else begin
      link_silence_fault_config <= next_config;
      counter_clear_inhibit <= next_inhibit;
    end
  end

  // prescaler and shared silence counter
  always_comb begin
    next_prescale = tick ? 16'h0000 : prescale + 16'h0001;
    next_counter = silence_counter;
    // shared 4 kHz up-counter, saturating so it never wraps past 1 h
    if (tick && silence_counter != 24'hFFFFFF) begin
      next_counter = silence_counter + 24'h000001;
    end
    // a valid frame restarts the silence window unless clearing is inhibited, prescaler phase included,
    // so a period never comes up short by a partial tick
    if (I_FRAME_VALID && !counter_clear_inhibit) begin
      next_counter = 24'h000000;
      next_prescale = 16'h0000;
    end
    // software load wins over frame clear, it is the explicit request
    if (wr_en && I_PADDR == `ADDR_SILENCE_COUNTER) begin
      next_counter = I_PWDATA[23:0];
    end
  end

  // counter registers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      prescale <= 16'h0000;
      silence_counter <= 24'h000000;
    end else begin
      prescale <= next_prescale;
      silence_counter <= next_counter;
    end
  end

  // fault flag and power-down request, both compared against the one counter
  always_comb begin
    next_fault = link_silence_fault;
    next_powerdown = powerdown;
    // write one to clear the fault flag
    if (wr_en && I_PADDR == `ADDR_SYSTEM_FAULT_REG && I_PWDATA[`FAULT_LINK_SILENCE_BIT]) begin
      next_fault = 1'b0;
    end
    // set wins over a same-cycle software clear
    if (fault_limit != 24'h000000 && silence_counter >= fault_limit) begin
      next_fault = 1'b1;
    end
    // power-down is sticky until reset: the device is going away
    if (pd_limit != 24'h000000 && silence_counter >= pd_limit) begin
      next_powerdown = 1'b1;
    end
  end

  // status flag registers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      link_silence_fault <= 1'b0;
      powerdown <= 1'b0;
    end else begin
      link_silence_fault <= next_fault;
      powerdown <= next_powerdown;
    end
  end

  // read data and slave error are taken in the setup cycle, so the
  // zero-wait access cycle answers from flip-flops
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (rd_en) begin
      unique case (I_PADDR)
        `ADDR_LINK_SILENCE_FAULT_CONFIG: next_prdata = {24'h000000, link_silence_fault_config};
        `ADDR_SILENCE_COUNTER: next_prdata = {8'h00, silence_counter};
        `ADDR_SILENCE_CONTROL: next_prdata = {31'h00000000, counter_clear_inhibit};
        `ADDR_SYSTEM_FAULT_REG: next_prdata = {31'h00000000, link_silence_fault};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (I_PSEL && !I_PENABLE) begin
      next_pslverr = ~addr_hit;
    end
  end

  // apb answer registers
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // outputs
  assign O_PRDATA = prdata;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = pslverr & I_PSEL & I_PENABLE;
  assign O_LINK_SILENCE_FAULT = link_silence_fault;
  assign O_POWERDOWN = powerdown;

endmodule

// [test/silence_host.sv]
/* frame host model: turns a bench request into a one-cycle valid-frame strobe.
   assumes the supervisor samples frames on the rising edge of the same clock. */
`timescale 1ns/10ps
module silence_host (
  // clock and request
  input wire logic i_clk,
  input wire logic i_send,
  // frame strobe toward the device
  output logic o_frame
);
  // registered, so the strobe never moves in the request's own time step
  always_ff @(posedge i_clk) o_frame <= i_send;
endmodule

// [test/comm_silence_timeout_properties.sv]
/* checker for comm_silence_timeout: apb answers, config read-back, sticky outputs.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module comm_silence_timeout_properties (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_FRAME_VALID,
  input wire logic O_LINK_SILENCE_FAULT,
  input wire logic O_POWERDOWN
);
  logic [7:0] cfg, next_cfg;
  logic acc, cfg_wr, clr_wr, mapped;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  // shadow of the config register, so disabled codes and reads can be judged
  assign acc = I_PSEL && I_PENABLE;
  assign cfg_wr = acc && I_PWRITE && I_PADDR == 12'h028;
  assign clr_wr = acc && I_PWRITE && I_PADDR == 12'h034 && I_PWDATA[0];
  assign mapped = I_PADDR inside {12'h028, 12'h02C, 12'h030, 12'h034};
  always_comb next_cfg = I_SYS_RST ? 8'h00 : (cfg_wr ? I_PWDATA[7:0] : cfg);
  always_ff @(posedge I_REF_CLK) cfg <= next_cfg;
  zero_wait_a: assert property (acc |-> O_PREADY) else $error("no ready in access");
  map_err_a: assert property (acc |-> O_PSLVERR == !mapped) else $error("wrong slave error");
  cfg_read_a: assert property (acc && !I_PWRITE && I_PADDR == 12'h028 |-> O_PRDATA == {24'h0, cfg})
    else $error("config read mismatch");
  pd_off_a: assert property (cfg[7:4] == 4'h0 && !cfg_wr && !O_POWERDOWN |=> !O_POWERDOWN)
    else $error("power-down while disabled");
  fault_off_a: assert property (cfg[3:0] == 4'h0 && !cfg_wr && !O_LINK_SILENCE_FAULT |=> !O_LINK_SILENCE_FAULT)
    else $error("fault while disabled");
  pd_hold_a: assert property (O_POWERDOWN |=> O_POWERDOWN) else $error("power-down dropped");
  fault_hold_a: assert property (O_LINK_SILENCE_FAULT && !clr_wr |=> O_LINK_SILENCE_FAULT)
    else $error("fault dropped without clear");
  rst_out_a: assert property ($fell(I_SYS_RST) |-> !O_POWERDOWN && !O_LINK_SILENCE_FAULT)
    else $error("outputs not cleared by reset");
  cover property ($rose(O_POWERDOWN));
  cover property ($rose(O_LINK_SILENCE_FAULT));
  cover property (acc && O_PSLVERR);
endmodule
bind comm_silence_timeout comm_silence_timeout_properties i_comm_silence_timeout_properties (.*);

// [test/test_comm_silence_timeout.sv]
/* bench for comm_silence_timeout: apb tasks, period ladder, zero codes, tick rate.
   assumes the design, checker and frame host model are compiled first. */
`timescale 1ns/10ps
module test_comm_silence_timeout;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, send = 0, frm, flt, pd, rdy, err, perr;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rd, r;
  int n_mismatch = 0, checks = 0;
  int unsigned ds[13] = '{1, 5, 10, 20, 50, 100, 300, 600, 1200, 3000, 6000, 18000, 36000};
  always #2 clk = ~clk;
  comm_silence_timeout i_comm_silence_timeout (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(adr), .I_PWDATA(wd), .O_PRDATA(rd), .O_PREADY(rdy), .O_PSLVERR(err),
    .I_FRAME_VALID(frm), .O_LINK_SILENCE_FAULT(flt), .O_POWERDOWN(pd));
  silence_host i_silence_host (.i_clk(clk), .i_send(send), .o_frame(frm));
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for ready however long it takes
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    r = rd;
    perr = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task do_reset();
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask
  // one frame pulse from the host model
  task frame();
    send <= 1'h1;
    @(posedge clk);
    send <= 1'h0;
  endtask
  // zero codes, frame clear, write-one-clear, unmapped access
  task t_zero();
    do_reset();
    apb(1'h0, 12'h028, 32'h0);
    chk(r, 32'h0);
    apb(1'h1, 12'h02C, 32'h00FFFFFF);
    repeat (3) @(posedge clk);
    chk({flt, pd}, 2'h0);
    apb(1'h1, 12'h028, 32'h1);
    repeat (3) @(posedge clk);
    chk({flt, pd}, 2'h2);
    frame();
    apb(1'h0, 12'h02C, 32'h0);
    chk(r, 32'h0);
    apb(1'h1, 12'h034, 32'h1);
    apb(1'h0, 12'h040, 32'h0);
    chk({perr, flt}, 2'h2);
    $display("zero test done");
  endtask
  // every code of both fields, one below and at its limit; codes 14 and 15 never written
  task t_ladder();
    for (int k = 1; k <= 13; k++) begin
      do_reset();
      apb(1'h1, 12'h028, {24'h0, k[3:0], k[3:0]});
      apb(1'h1, 12'h02C, ds[k-1] * 400 - 1);
      repeat (3) @(posedge clk);
      chk({flt, pd}, 2'h0);
      apb(1'h1, 12'h02C, ds[k-1] * 400);
      repeat (3) @(posedge clk);
      chk({flt, pd}, 2'h3);
    end
    $display("ladder test done");
  endtask
  // power-down period set above the fault period: the fault comes first
  task t_order();
    do_reset();
    apb(1'h1, 12'h028, 32'h00000021);
    apb(1'h1, 12'h02C, 32'd400);
    repeat (3) @(posedge clk);
    chk({flt, pd}, 2'h2);
    apb(1'h1, 12'h02C, 32'd2000);
    repeat (3) @(posedge clk);
    chk({flt, pd}, 2'h3);
    $display("order test done");
  endtask
  // one real 4 kHz tick with clearing inhibited, frame ignored
  task t_tick();
    do_reset();
    apb(1'h1, 12'h028, 32'h1);
    apb(1'h1, 12'h030, 32'h1);
    apb(1'h1, 12'h02C, 32'd399);
    frame();
    repeat (62510) @(posedge clk);
    chk(flt, 1'h1);
    apb(1'h0, 12'h02C, 32'h0);
    chk(r, 32'd400);
    $display("tick test done");
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    t_zero();
    t_ladder();
    t_order();
    t_tick();
    end_sim();
  end
  // watchdog, a little beyond the one long tick wait
  initial begin
    #280000;
    n_mismatch++;
    end_sim();
  end
endmodule
